// ### tpd_pkg.sv
// Package of constants for the keep-alive PWM drive gate.
// Assumes a single 125 MHz system clock shared by all users of these names.
package tpd_pkg;

  // ************************************************************
  // Clock and timing.
  // ************************************************************
  localparam int unsigned CLK_MHZ        = 125;
  localparam int unsigned WINDOW_US      = 200;
  localparam int unsigned WINDOW_CYCLES  = WINDOW_US * CLK_MHZ;
  localparam int unsigned MAX_CMD_KHZ    = 160;
  localparam int unsigned MIN_CMD_PERIOD = (CLK_MHZ * 1000) / MAX_CMD_KHZ;

  // ************************************************************
  // Keep-alive defaults, in microseconds and in system clock cycles.
  // ************************************************************
  localparam int unsigned TICKLE_THRESH_US = 1;
  localparam int unsigned TICKLE_THRESH_CYCLES = TICKLE_THRESH_US * CLK_MHZ;
  localparam int unsigned TICKLE_LEN_CYCLES    = TICKLE_THRESH_CYCLES;

  // ************************************************************
  // Widths and reset values.
  // ************************************************************
  localparam int unsigned CNT_W     = 16;
  localparam logic        DRIVE_RST = 1'b0;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_TICKLE
  } tpd_state_type;

endpackage : tpd_pkg

// ### tpd_on_meter.sv
// On-time meter: counts cycles with driveOn high inside one window.
// Assumes the window pulse and command are synchronous to ref_clk.
`timescale 1ns/1ps
module tpd_on_meter #(
  parameter int unsigned CNT_W = tpd_pkg::CNT_W
) (
  input  wire logic             ref_clk,
  input  wire logic             arst_n,
  input  wire logic             windowEnd,
  input  wire logic             driveOn,
  output logic      [CNT_W-1:0] onTime_q
);

  // ************************************************************
  // Saturating counter, restarted at each window boundary.
  // ************************************************************
  logic [CNT_W-1:0] acc_q;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_q <= '0;
    end else if (windowEnd) begin
      acc_q <= {{(CNT_W-1){1'b0}}, driveOn};
    end else if (driveOn && (acc_q != {CNT_W{1'b1}})) begin
      acc_q <= acc_q + 1'b1;
    end
  end

  // Total of the window that just closed, held for the next window.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      onTime_q <= '0;
    end else if (windowEnd) begin
      onTime_q <= acc_q + {{(CNT_W-1){1'b0}}, driveOn};
    end
  end

endmodule : tpd_on_meter

// ### tpd_drive_gate.sv
// Drive gate: RF enable follows the PWM command, with keep-alive pulses.
// Assumes the command input is already synchronous to ref_clk.
`timescale 1ns/1ps
// How it works
// - Measure drive on-time (command or keep-alive) in every 200 us window.
// - Enough on-time in a window means no keep-alive pulse follows.
// - Too little or no on-time inserts one keep-alive pulse.
// - RF enable follows the command, high while it is high.
// - Commands from DC up to 160 kHz are followed cycle by cycle.
// - A constantly high command keeps drive on continuously.
module tpd_drive_gate #(
  parameter int unsigned WINDOW_CYCLES = tpd_pkg::WINDOW_CYCLES,
  parameter int unsigned THRESH_CYCLES = tpd_pkg::TICKLE_THRESH_CYCLES,
  parameter int unsigned TICKLE_CYCLES = tpd_pkg::TICKLE_LEN_CYCLES,
  parameter int unsigned CNT_W         = tpd_pkg::CNT_W
) (
  input  wire logic ref_clk,
  input  wire logic arst_n,
  input  wire logic pwmCmd,
  output logic      rfEnable_q,
  output logic      tickleActive_q,
  output logic      windowEnd_q
);

  localparam logic [CNT_W-1:0] WIN_LAST = CNT_W'(WINDOW_CYCLES - 1);
  localparam logic [CNT_W-1:0] THRESH   = CNT_W'(THRESH_CYCLES);
  localparam logic [CNT_W-1:0] TCK_LAST = CNT_W'(TICKLE_CYCLES - 1);

  // ************************************************************
  // Window timer.
  // ************************************************************
  logic [CNT_W-1:0] winCnt_q;
  logic             winEnd;

  assign winEnd = (winCnt_q == WIN_LAST);

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      winCnt_q <= '0;
    end else if (winEnd) begin
      winCnt_q <= '0;
    end else begin
      winCnt_q <= winCnt_q + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      windowEnd_q <= 1'b0;
    end else begin
      windowEnd_q <= winEnd;
    end
  end

  // ************************************************************
  // On-time measurement.
  // ************************************************************
  logic [CNT_W-1:0] onTime;
  logic             driveOn;

  // Keep-alive pulses count as drive, but a default-length pulse alone only equals the threshold and does not exceed it.
  assign driveOn = pwmCmd || tickleActive_q;

  tpd_on_meter #(
    .CNT_W     (CNT_W)
  ) u_meter (
    .ref_clk   (ref_clk),
    .arst_n    (arst_n),
    .windowEnd (winEnd),
    .driveOn   (driveOn),
    .onTime_q  (onTime)
  );

  // ************************************************************
  // Keep-alive pulse generator.
  // ************************************************************
  tpd_pkg::tpd_state_type state_q;
  logic [CNT_W-1:0]       tckCnt_q;
  logic                   shortWin_q;

  // Decision is taken one cycle after the window closes.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      shortWin_q <= 1'b0;
    end else begin
      shortWin_q <= windowEnd_q && !(onTime > THRESH);
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q  <= tpd_pkg::ST_IDLE;
      tckCnt_q <= '0;
    end else begin
      case (state_q)
        tpd_pkg::ST_IDLE: begin
          if (shortWin_q) begin
            state_q  <= tpd_pkg::ST_TICKLE;
            tckCnt_q <= '0;
          end
        end
        tpd_pkg::ST_TICKLE: begin
          if (tckCnt_q == TCK_LAST) begin
            state_q <= tpd_pkg::ST_IDLE;
          end else begin
            tckCnt_q <= tckCnt_q + 1'b1;
          end
        end
        default: begin
          state_q <= tpd_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tickleActive_q <= 1'b0;
    end else begin
      tickleActive_q <= (state_q == tpd_pkg::ST_IDLE) ? shortWin_q
                      : (tckCnt_q != TCK_LAST);
    end
  end

  // ************************************************************
  // RF enable.
  // ************************************************************
  // The command passes through one flop only, so any rate up to half the
  // clock's is followed, far beyond the 160 kHz ceiling.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rfEnable_q <= tpd_pkg::DRIVE_RST;
    end else begin
      rfEnable_q <= pwmCmd || tickleActive_q;
    end
  end

endmodule : tpd_drive_gate

// ### tpd_gate_checker.sv
// Port assertions for the keep-alive drive gate.
// Assumes a 50-cycle window and a 4-cycle keep-alive pulse.
`timescale 1ns/1ps
module tpd_gate_checker (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic pwmCmd,
  input wire logic rfEnable_q,
  input wire logic tickleActive_q,
  input wire logic windowEnd_q
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  follow_cmd_a: assert property (pwmCmd |=> rfEnable_q)
    else $error("drive missed command");
  drive_off_a: assert property (!pwmCmd && !tickleActive_q |=> !rfEnable_q)
    else $error("drive without cause");
  tickle_drive_a: assert property (tickleActive_q |=> rfEnable_q)
    else $error("keep-alive not driven");
  tickle_len_a: assert property ($rose(tickleActive_q) |-> tickleActive_q[*4] ##1 !tickleActive_q)
    else $error("keep-alive length wrong");
  tickle_start_a: assert property ($rose(tickleActive_q) |-> $past(windowEnd_q, 2))
    else $error("keep-alive misplaced");
  end_pulse_a: assert property (windowEnd_q |=> !windowEnd_q)
    else $error("window end too long");
  window_period_a: assert property (windowEnd_q |-> ##50 windowEnd_q)
    else $error("window length wrong");
  busy_skip_a: assert property (pwmCmd[*8] ##1 windowEnd_q |-> ##2 !tickleActive_q)
    else $error("keep-alive after busy window");
endmodule : tpd_gate_checker

bind tpd_drive_gate tpd_gate_checker chk (.ref_clk, .arst_n, .pwmCmd,
  .rfEnable_q, .tickleActive_q, .windowEnd_q);

// ### tpd_cmd_source.sv
// Behavioural PWM command source for the drive gate.
// Assumes it shares ref_clk and the bench sets period and high time.
`timescale 1ns/1ps
module tpd_cmd_source (
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  input  wire logic [7:0] period,
  input  wire logic [7:0] highCycles,
  output logic            pwmCmd
);
  logic [7:0] phase_q = 8'h00;
  initial pwmCmd = 1'b0;
  // No keep-alive pulses are sent; a zero high time leaves the line low.
  always @(posedge ref_clk) begin
    #1;
    phase_q <= (phase_q + 8'h01 >= period) ? 8'h00 : phase_q + 8'h01;
    pwmCmd <= arst_n && (phase_q < highCycles);
  end
endmodule : tpd_cmd_source

// ### testbench.sv
// Self-checking bench for the keep-alive drive gate.
// Assumes a behavioural command source on the gate input.
`timescale 1ns/1ps
module testbench;
  logic       ref_clk = 1'b0;
  logic       arst_n = 1'b0;
  logic [7:0] period = 8'h08;
  logic [7:0] highCycles = 8'h00;
  logic       pwmCmd, rfEnable_q, tickleActive_q, windowEnd_q;
  int         errors = 0;
  int         checked = 0;
  always #4 ref_clk = ~ref_clk;
  tpd_cmd_source src (.ref_clk(ref_clk), .arst_n(arst_n), .period(period),
    .highCycles(highCycles), .pwmCmd(pwmCmd));
  tpd_drive_gate #(.WINDOW_CYCLES(50), .THRESH_CYCLES(4), .TICKLE_CYCLES(4))
    dut (.ref_clk(ref_clk), .arst_n(arst_n), .pwmCmd(pwmCmd),
    .rfEnable_q(rfEnable_q), .tickleActive_q(tickleActive_q),
    .windowEnd_q(windowEnd_q));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  task automatic wrap_up;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  task automatic wait_end;
    int n = 0;
    while (windowEnd_q !== 1'b1) begin
      @(posedge ref_clk);
      #1;
      n++;
      if (n > 60) begin
        errors++;
        wrap_up();
      end
    end
    @(posedge ref_clk);
    #1;
  endtask : wait_end
  task automatic count_win(input logic [7:0] expOn, input logic [7:0] expTk);
    logic [7:0] on = 8'h00;
    logic [7:0] tk = 8'h00;
    logic [7:0] we = 8'h00;
    repeat (50) begin
      if (rfEnable_q === 1'b1) on++;
      if (tickleActive_q === 1'b1) tk++;
      if (windowEnd_q === 1'b1) we++;
      @(posedge ref_clk);
      #1;
    end
    chk("window ends", 8'h01, we);
    chk("drive cycles", expOn, on);
    chk("keep-alive cycles", expTk, tk);
  endtask : count_win
  task automatic idle_test;
    highCycles = 8'h00;
    wait_end();
    wait_end();
    count_win(8'h04, 8'h04);
  endtask : idle_test
  task automatic busy_test;
    highCycles = 8'h08;
    wait_end();
    wait_end();
    count_win(8'h32, 8'h00);
  endtask : busy_test
  task automatic pwm_test;
    logic prev;
    highCycles = 8'h03;
    wait_end();
    repeat (40) begin
      @(negedge ref_clk);
      prev = pwmCmd;
      @(posedge ref_clk);
      #1;
      chk("drive follows command", {7'h00, prev}, {7'h00, rfEnable_q});
    end
  endtask : pwm_test
  initial begin
    repeat (2) @(posedge ref_clk);
    #1 arst_n = 1'b1;
    idle_test();
    busy_test();
    pwm_test();
    wrap_up();
  end
endmodule : testbench
